// ===== logic/scp_ctrl.sv
// sideband control path: output holding, pause control, event notices, receive checks, retries
//
// Summary of operation
// - hold pass-through while blocked from transmitting
// - keep event notices pending under same blocking; aen_valid itself not gated
// - hold responses while arbitrating without token
// - each channel requests XOFF at most one hold interval
// - after second interval channel re-initialises, withdraws
// - package XOFF ORs all channel requests
// - each notice type gated by enable
// - notices sent once, never retransmitted
// - notice header carries originating channel
// - notice instance identifier is zero
// - stored manager tag goes into notices
// - notices only while link active, unqueued
// - drop packets with bad fcs, length, checksum
// - drop wrong channel, no resources, bad revision
// - may drop packets during initial entry
// - retried command replays without side effects
// - initial entry stops pass-through both ways
// - response copies command instance identifier
`timescale 1ns/10ps
`include "scp_map.svh"
module scp_ctrl #(
  parameter int NCH = 4,
  parameter int NEVT = 8,
  parameter int PAUSE_HOLD_CYC = `SCP_PAUSE_HOLD_US * 1000 / `SCP_CLK_NS
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // link state
  input wire logic link_active,
  input wire logic token_held,
  // pass-through transmit and receive accept, one stream per channel
  input wire logic [NCH-1:0] pt_valid,
  output logic [NCH-1:0] pt_ready,
  output logic [NCH-1:0] pt_rx_accept,
  // flow control
  input wire logic [NCH-1:0] congested,
  output logic pause_xoff,
  output logic [NCH-1:0] chan_reinit,
  // event sources and notice output
  input wire logic evt_valid,
  input wire logic [$clog2(NEVT)-1:0] evt_kind,
  input wire logic [4:0] evt_chan,
  output logic aen_valid,
  output scp_pkg::scp_hdr_type aen_hdr,
  input wire logic aen_ready,
  // received control packets
  input wire logic rx_valid,
  input wire scp_pkg::scp_rx_type rx_pkt,
  input wire logic [4:0] rx_expect_chan,
  output logic rx_drop,
  // command execution and response
  output logic cmd_exec,
  output logic cmd_replay,
  output scp_pkg::scp_hdr_type rsp_hdr,
  output logic rsp_valid,
  input wire logic rsp_ready
);
  localparam int TW = $clog2(2 * PAUSE_HOLD_CYC + 2);
  localparam logic [TW-1:0] HOLD1 = TW'(PAUSE_HOLD_CYC);
  localparam logic [TW-1:0] HOLD2 = TW'(2 * PAUSE_HOLD_CYC);

  logic [2:0] ctrl, next_ctrl;
  logic [NCH-1:0] ch_en, next_ch_en;
  logic [NCH-1:0] ch_init, next_ch_init;
  logic [NEVT-1:0] aen_en, next_aen_en;
  logic [7:0] mgr_tag, next_mgr_tag;
  logic [15:0] drops, next_drops;
  logic [TW-1:0] tmr [NCH];
  logic [TW-1:0] next_tmr [NCH];
  logic [NCH-1:0] xoff_req, next_xoff_req;
  logic [NCH-1:0] next_chan_reinit;
  logic wr_pend, next_wr_pend;
  logic [`SCP_ADDR_W-1:0] wr_addr, next_wr_addr;
  logic [31:0] next_hrdata;
  logic next_aen_valid;
  scp_pkg::scp_hdr_type next_aen_hdr, next_rsp_hdr;
  scp_pkg::scp_rsp_state_type rsp_st, next_rsp_st;
  logic have_last, next_have_last;
  logic [12:0] last_cmd, next_last_cmd;
  logic next_cmd_exec, next_cmd_replay, next_rx_drop;
  logic tx_ok, rx_ok, addr_ph;
  int ci;

  function automatic logic [31:0] status_word(input logic [NCH-1:0] init,
                                              input logic [NCH-1:0] xo,
                                              input logic tok, input logic lnk,
                                              input logic rsp);
    logic [31:0] w;
    w = '0;
    for (int i = 0; i < NCH; i++) begin
      w[`SCP_ST_INIT + i] = init[i];
      w[`SCP_ST_XOFF + i] = xo[i];
    end
    w[`SCP_ST_TOKEN] = tok;
    w[`SCP_ST_LINK] = lnk;
    w[`SCP_ST_RSP] = rsp;
    return w;
  endfunction

  // transmit is allowed only when selected and, under arbitration, holding the token
  assign tx_ok = ctrl[`SCP_CTRL_SEL] & (~ctrl[`SCP_CTRL_ARB] | token_held);
  assign addr_ph = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // a held stream keeps its own order because nothing is taken until ready
  assign pt_ready = {NCH{tx_ok}} & ch_en & ~ch_init;
  assign pt_rx_accept = ch_en & ~ch_init;
  assign pause_xoff = ctrl[`SCP_CTRL_FC] & (|xoff_req);
  assign rsp_valid = (rsp_st == scp_pkg::SCP_RSP_HOLD) & tx_ok;

  always_comb begin
    next_ctrl = ctrl;
    next_ch_en = ch_en;
    next_ch_init = ch_init;
    next_aen_en = aen_en;
    next_mgr_tag = mgr_tag;
    next_drops = drops;
    next_wr_pend = addr_ph & hwrite;
    next_wr_addr = addr_ph ? haddr[`SCP_ADDR_W-1:0] : wr_addr;
    next_hrdata = hrdata;
    next_tmr = tmr;
    next_xoff_req = xoff_req;
    next_chan_reinit = '0;
    next_aen_valid = aen_valid;
    next_aen_hdr = aen_hdr;
    next_rsp_st = rsp_st;
    next_rsp_hdr = rsp_hdr;
    next_have_last = have_last;
    next_last_cmd = last_cmd;
    next_cmd_exec = 1'b0;
    next_cmd_replay = 1'b0;
    next_rx_drop = 1'b0;
    rx_ok = 1'b0;
    ci = 0;

    // register writes land in the data phase
    if (wr_pend) begin
      case (wr_addr)
        `SCP_OFF_CTRL: next_ctrl = hwdata[2:0];
        `SCP_OFF_CH_EN: begin
          next_ch_en = hwdata[NCH-1:0];
          // enabling a channel takes it out of the initial state
          next_ch_init = ch_init & ~hwdata[NCH-1:0];
        end
        `SCP_OFF_AEN_EN: next_aen_en = hwdata[NEVT-1:0];
        `SCP_OFF_MGR_TAG: next_mgr_tag = hwdata[7:0];
        default: ;
      endcase
    end
    // read data is sampled at the address phase, so a read right after a write shows the old value
    if (addr_ph & ~hwrite) begin
      case (haddr[`SCP_ADDR_W-1:0])
        `SCP_OFF_CTRL: next_hrdata = {29'h0, ctrl};
        `SCP_OFF_CH_EN: next_hrdata = 32'(ch_en);
        `SCP_OFF_AEN_EN: next_hrdata = 32'(aen_en);
        `SCP_OFF_MGR_TAG: next_hrdata = {24'h0, mgr_tag};
        `SCP_OFF_STATUS: next_hrdata = status_word(ch_init, xoff_req, token_held, link_active,
                                                   rsp_st == scp_pkg::SCP_RSP_HOLD);
        `SCP_OFF_DROPS: next_hrdata = {16'h0, drops};
        default: next_hrdata = 32'h0;
      endcase
    end

    // per-channel pause timer: xoff for one interval, re-init after the second
    for (int i = 0; i < NCH; i++) begin
      if (~congested[i] | ~ctrl[`SCP_CTRL_FC] | ch_init[i]) begin
        next_tmr[i] = '0;
        next_xoff_req[i] = 1'b0;
      end else if (tmr[i] < HOLD2) begin
        next_tmr[i] = tmr[i] + TW'(1);
        next_xoff_req[i] = (tmr[i] + TW'(1)) < HOLD1;
        if ((tmr[i] + TW'(1)) == HOLD2) begin
          next_ch_init[i] = 1'b1;
          next_chan_reinit[i] = 1'b1;
          next_xoff_req[i] = 1'b0;
        end
      end
    end

    // event notices: one shot, no retransmission; the core does not see a drop
    if (~link_active) begin
      next_aen_valid = 1'b0;
    end else begin
      if (aen_valid & aen_ready & tx_ok) begin
        next_aen_valid = 1'b0;
      end
      // a new event while one is held is lost rather than queued, keeping cost to one slot
      if (evt_valid & aen_en[evt_kind] & ~next_aen_valid) begin
        next_aen_valid = 1'b1;
        next_aen_hdr.mgr_tag = mgr_tag;
        next_aen_hdr.chan = evt_chan;
        next_aen_hdr.instance_identifier = `SCP_AEN_IID;
        next_aen_hdr.kind = 8'(evt_kind);
      end
    end

    // receive checks
    if (rx_valid) begin
      ci = int'(rx_pkt.chan[2:0]);
      rx_ok = rx_pkt.fcs_ok & (rx_pkt.len_ok | rx_pkt.oem_long)
            & (~rx_pkt.cksum_present | rx_pkt.cksum_ok)
            & (rx_pkt.chan == rx_expect_chan)
            & (rx_pkt.hdr_rev == `SCP_HDR_REV)
            & (rsp_st == scp_pkg::SCP_RSP_IDLE);
      if (ci < NCH) begin
        rx_ok = rx_ok & ~chan_reinit[ci];
      end
      if (rx_ok) begin
        if (have_last & (last_cmd == {rx_pkt.chan, rx_pkt.instance_identifier})) begin
          next_cmd_replay = 1'b1;
        end else begin
          next_cmd_exec = 1'b1;
        end
        next_have_last = 1'b1;
        next_last_cmd = {rx_pkt.chan, rx_pkt.instance_identifier};
        next_rsp_hdr.mgr_tag = mgr_tag;
        next_rsp_hdr.chan = rx_pkt.chan;
        next_rsp_hdr.instance_identifier = rx_pkt.instance_identifier;
        next_rsp_hdr.kind = rx_pkt.kind;
      end else begin
        next_rx_drop = 1'b1;
        next_drops = drops + 16'h0001;
      end
    end

    // response held until the transmit path is free
    case (rsp_st)
      scp_pkg::SCP_RSP_IDLE: begin
        if (rx_valid & rx_ok) begin
          next_rsp_st = scp_pkg::SCP_RSP_HOLD;
        end
      end
      scp_pkg::SCP_RSP_HOLD: begin
        if (tx_ok & rsp_ready) begin
          next_rsp_st = scp_pkg::SCP_RSP_IDLE;
        end
      end
      default: next_rsp_st = scp_pkg::SCP_RSP_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (~reset_n) begin
      ctrl <= `SCP_CTRL_RST;
      ch_en <= '0;
      ch_init <= '1;
      aen_en <= NEVT'(`SCP_AEN_RST);
      mgr_tag <= `SCP_TAG_RST;
      drops <= 16'h0000;
      for (int i = 0; i < NCH; i++) begin
        tmr[i] <= '0;
      end
      xoff_req <= '0;
      chan_reinit <= '0;
      wr_pend <= 1'b0;
      wr_addr <= '0;
      hrdata <= 32'h0;
      aen_valid <= 1'b0;
      aen_hdr <= '0;
      rsp_st <= scp_pkg::SCP_RSP_IDLE;
      rsp_hdr <= '0;
      have_last <= 1'b0;
      last_cmd <= '0;
      cmd_exec <= 1'b0;
      cmd_replay <= 1'b0;
      rx_drop <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      ch_en <= next_ch_en;
      ch_init <= next_ch_init;
      aen_en <= next_aen_en;
      mgr_tag <= next_mgr_tag;
      drops <= next_drops;
      tmr <= next_tmr;
      xoff_req <= next_xoff_req;
      chan_reinit <= next_chan_reinit;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
      aen_valid <= next_aen_valid;
      aen_hdr <= next_aen_hdr;
      rsp_st <= next_rsp_st;
      rsp_hdr <= next_rsp_hdr;
      have_last <= next_have_last;
      last_cmd <= next_last_cmd;
      cmd_exec <= next_cmd_exec;
      cmd_replay <= next_cmd_replay;
      rx_drop <= next_rx_drop;
    end
  end
endmodule

// ===== logic/scp_map.svh
// register map, field positions, reset values and timing constants of the sideband control path
`ifndef SCP_MAP_SVH
`define SCP_MAP_SVH
`define SCP_ADDR_W 8
`define SCP_OFF_CTRL 8'h00
`define SCP_OFF_CH_EN 8'h04
`define SCP_OFF_AEN_EN 8'h08
`define SCP_OFF_MGR_TAG 8'h0c
`define SCP_OFF_STATUS 8'h10
`define SCP_OFF_DROPS 8'h14
`define SCP_CTRL_SEL 0
`define SCP_CTRL_ARB 1
`define SCP_CTRL_FC 2
`define SCP_ST_INIT 0
`define SCP_ST_XOFF 8
`define SCP_ST_TOKEN 16
`define SCP_ST_LINK 17
`define SCP_ST_RSP 18
`define SCP_CTRL_RST 3'h0
`define SCP_AEN_RST 8'h00
`define SCP_TAG_RST 8'h00
`define SCP_AEN_IID 8'h00
`define SCP_HDR_REV 8'h01
`define SCP_CLK_NS 50
`define SCP_PAUSE_HOLD_US 1000
`endif

// ===== logic/scp_pkg.sv
// types shared by the sideband control path
package scp_pkg;
  typedef struct packed {
    logic [7:0] mgr_tag;
    logic [4:0] chan;
    logic [7:0] instance_identifier;
    logic [7:0] kind;
  } scp_hdr_type;
  typedef struct packed {
    logic fcs_ok;
    logic len_ok;
    logic oem_long;
    logic cksum_present;
    logic cksum_ok;
    logic [4:0] chan;
    logic [7:0] hdr_rev;
    logic [7:0] instance_identifier;
    logic [7:0] kind;
  } scp_rx_type;
  typedef enum logic [1:0] {
    SCP_RSP_IDLE = 2'b01,
    SCP_RSP_HOLD = 2'b10
  } scp_rsp_state_type;
endpackage

// ===== verif/scp_ctrl_sva.sv
// port checker for the sideband control path
`timescale 1ns/10ps
module scp_ctrl_sva #(
  parameter int NCH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // bus and link
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic link_active,
  // channels
  input wire logic [NCH-1:0] congested,
  input wire logic [NCH-1:0] pt_rx_accept,
  input wire logic [NCH-1:0] chan_reinit,
  input wire logic pause_xoff,
  // notices
  input wire logic aen_valid,
  input wire scp_pkg::scp_hdr_type aen_hdr,
  // control packets
  input wire logic rx_valid,
  input wire scp_pkg::scp_rx_type rx_pkt,
  input wire logic [4:0] rx_expect_chan,
  input wire logic rx_drop,
  input wire logic cmd_exec,
  input wire logic cmd_replay,
  input wire scp_pkg::scp_hdr_type rsp_hdr
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  bus_okay_a:
    assert property (hreadyout && !hresp) else $error("bus stall or error");
  notice_iid_a:
    assert property (aen_valid |-> aen_hdr.instance_identifier == 8'h00) else $error("notice iid");
  notice_link_a:
    assert property (!link_active |=> !aen_valid) else $error("notice while link down");
  rx_single_a:
    assert property (rx_valid |=> $onehot({rx_drop, cmd_exec, cmd_replay}))
      else $error("rx outcome count");
  rx_quiet_a:
    assert property (!rx_valid |=> !(rx_drop || cmd_exec || cmd_replay))
      else $error("rx outcome without packet");
  rx_fcs_a:
    assert property (rx_valid && !rx_pkt.fcs_ok |=> rx_drop) else $error("bad fcs kept");
  rx_chan_a:
    assert property (rx_valid && rx_pkt.chan != rx_expect_chan |=> rx_drop)
      else $error("wrong channel kept");
  rx_rev_a:
    assert property (rx_valid && rx_pkt.hdr_rev != 8'h01 |=> rx_drop)
      else $error("wrong revision kept");
  rsp_iid_a:
    assert property (cmd_exec || cmd_replay |-> rsp_hdr.instance_identifier == $past(rx_pkt.instance_identifier))
      else $error("response iid");
  xoff_cause_a:
    assert property ($rose(pause_xoff) |-> $past(congested) != '0) else $error("xoff cause");
  reinit_pulse_a:
    assert property (chan_reinit != '0 |=> chan_reinit == '0) else $error("reinit pulse");
  reinit_block_a:
    assert property (chan_reinit != '0 |=> ~|(pt_rx_accept & $past(chan_reinit)))
      else $error("reinit channel still accepts");
endmodule
bind scp_ctrl scp_ctrl_sva #(.NCH(NCH)) chk (.*);

// ===== verif/scp_mc_model.sv
// management controller model at the far side of the control path
`timescale 1ns/10ps
module scp_mc_model #(
  parameter int TMO = 40
) (
  // clock
  input wire logic clk,
  // control packets
  output logic rx_valid,
  output scp_pkg::scp_rx_type rx_pkt,
  input wire logic rsp_valid,
  input wire scp_pkg::scp_hdr_type rsp_hdr,
  output logic rsp_ready,
  // notices and pacing
  output logic aen_ready,
  input wire logic slow
);
  logic ph = 1'b0;
  // the ready lines get their first value at the first edge, from their own process only
  initial {rx_valid, rx_pkt} = '0;
  // a slow controller takes only every other cycle
  always @(posedge clk) begin
    ph <= !ph;
    rsp_ready <= !slow || ph;
    aen_ready <= !slow || ph;
  end
  task automatic send(input scp_pkg::scp_rx_type p);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_pkt <= p;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_pkt <= ~p;
  endtask
  // stale duplicates carry another iid and are passed over
  task automatic command(input scp_pkg::scp_rx_type p);
    int n;
    int w;
    bit got;
    got = 1'b0;
    for (n = 0; n < 3 && !got; n++) begin
      send(p);
      for (w = 0; w < TMO && !got; w++) begin
        @(posedge clk);
        got = rsp_valid && rsp_ready && rsp_hdr.instance_identifier === p.instance_identifier;
      end
    end
  endtask
endmodule

// ===== verif/scp_ctrl_tb_top.sv
// self-checking bench for the sideband control path
`timescale 1ns/10ps
module scp_ctrl_tb_top;
  localparam int HOLD = 8;
  logic clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, evt_valid = 1'b0;
  logic link_active = 1'b1, token_held = 1'b0, slow = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, evt_kind = 3'h0;
  logic [3:0] pt_valid = 4'hf, congested = 4'h0, pt_ready, pt_rx_accept, chan_reinit;
  logic [4:0] evt_chan = 5'h00, rx_expect_chan = 5'h03, ch;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdv;
  logic [7:0] tag, en;
  logic hreadyout, hresp, pause_xoff, aen_valid, aen_ready, rx_valid, rx_drop;
  logic cmd_exec, cmd_replay, rsp_valid, rsp_ready;
  scp_pkg::scp_hdr_type aen_hdr, rsp_hdr;
  scp_pkg::scp_rx_type rx_pkt, p;
  int failures = 0, checked = 0, seed = 55, k;
  bit [10:0] q_rx[$];
  bit [28:0] q_aen[$];
  scp_ctrl #(.PAUSE_HOLD_CYC(HOLD)) dut (.*, .hready(hreadyout));
  scp_mc_model mc (.*);
  always #25 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge clk); while (!hreadyout);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge clk); while (!hreadyout);
    rdv = hrdata;
  endtask
  task automatic tally_and_finish;
    check(q_rx.size() + q_aen.size(), 0);
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    if (reset_n && (rx_drop || cmd_exec || cmd_replay))
      check({rx_drop, cmd_exec, cmd_replay, rx_drop ? 8'h00 : rsp_hdr.instance_identifier},
        q_rx.size() ? q_rx.pop_front() : 11'h7ff);
    if (reset_n && aen_valid && aen_ready)
      check(aen_hdr, q_aen.size() ? q_aen.pop_front() : 29'h0);
  end
  initial begin
    #(3000 * 50);
    failures++;
    tally_and_finish;
  end
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    bus(1'b0, 8'h10, 32'h0);
    check(rdv, 32'h0002000f);
    bus(1'b1, 8'h00, 32'h3);
    bus(1'b1, 8'h04, 32'hf);
    @(negedge clk) check(pt_ready, 4'h0);
    @(posedge clk) token_held <= 1'b1;
    @(negedge clk) check(pt_ready, 4'hf);
    bus(1'b1, 8'h20, $random(seed));
    bus(1'b0, 8'h20, 32'h0);
    check(rdv, 32'h0);
    tag = 8'h80 | $random(seed);
    en = ($random(seed) | 8'h04) & 8'hf7;
    bus(1'b1, 8'h08, {24'h0, en});
    bus(1'b1, 8'h0c, {24'h0, tag});
    for (k = 0; k < 8; k++) begin
      ch = $random(seed);
      @(posedge clk);
      evt_valid <= 1'b1;
      evt_kind <= k[2:0];
      evt_chan <= ch;
      link_active <= k != 2;
      if (en[k] && k != 2) q_aen.push_back({tag, ch, 8'h00, 5'h0, k[2:0]});
      @(posedge clk);
      evt_valid <= 1'b0;
      link_active <= 1'b1;
      repeat (3) @(posedge clk);
    end
    p = {5'b11011, 5'h03, 8'h01, 8'h2a, 8'h07};
    q_rx.push_back({3'b010, 8'h2a});
    mc.command(p);
    q_rx.push_back({3'b001, 8'h2a});
    mc.command(p);
    for (k = 0; k < 5; k++) begin
      p = {5'b11011, 5'h03, 8'h01, 8'h30, 8'h01};
      case (k)
        0: p.fcs_ok = 1'b0;
        1: p.len_ok = 1'b0;
        2: p.cksum_ok = 1'b0;
        3: p.chan = 5'h04;
        default: p.hdr_rev = 8'h02;
      endcase
      q_rx.push_back(11'h400);
      mc.send(p);
    end
    q_rx.push_back({3'b010, 8'h40});
    mc.command({5'b10111, 5'h03, 8'h01, 8'h40, 8'h01});
    @(posedge clk) token_held <= 1'b0;
    q_rx.push_back({3'b010, 8'h41});
    mc.send({5'b11011, 5'h03, 8'h01, 8'h41, 8'h01});
    @(negedge clk) check(rsp_valid, 1'b0);
    q_rx.push_back(11'h400);
    mc.send({5'b11011, 5'h03, 8'h01, 8'h42, 8'h01});
    @(posedge clk) token_held <= 1'b1;
    slow <= 1'b1;
    bus(1'b0, 8'h10, 32'h0);
    check(rdv[18], 1'b0);
    bus(1'b0, 8'h14, 32'h0);
    check(rdv, 32'h6);
    bus(1'b1, 8'h00, 32'h7);
    @(posedge clk) congested <= 4'h1;
    repeat (4) @(posedge clk);
    congested <= 4'h3;
    repeat (6) @(posedge clk);
    @(negedge clk) check(pause_xoff, 1'b1);
    repeat (20) @(posedge clk);
    congested <= 4'h0;
    @(negedge clk) check(pause_xoff, 1'b0);
    bus(1'b0, 8'h10, 32'h0);
    // the status read doubles as the manager's poll for channels back in the initial state
    check(rdv[3:0], 4'h3);
    check(pt_ready, 4'hc);
    tally_and_finish;
  end
endmodule
